// ==== hprc_pkg.sv ====
// Purpose: Constants for the hub port removable and charge configuration registers
// Assumes: 8-bit configuration register space reached by the EEPROM loader or SMBus slave
// Notes: Offsets are byte addresses of the configuration space
package hprc_pkg;
  localparam int unsigned HPRC_ADDR_W = 8;
  localparam int unsigned HPRC_DATA_W = 8;
  localparam int unsigned HPRC_PORTS = 4;
  localparam logic [7:0] HPRC_OFS_CHARGE = 8'h06;
  localparam logic [7:0] HPRC_OFS_REMOVABLE = 8'h07;
  localparam int unsigned HPRC_UNLOCK_BIT = 7;
  localparam logic [3:0] HPRC_UPPER_ZERO = 4'h0;
  localparam logic [2:0] HPRC_RSVD_ZERO = 3'h0;
  localparam logic [7:0] HPRC_READ_ZERO = 8'h00;
  localparam logic [3:0] HPRC_CHARGE_RST = 4'h0;
  localparam logic [3:0] HPRC_RMBL_RST = 4'h0;
  localparam logic HPRC_UNLOCK_RST = 1'b0;
endpackage : hprc_pkg

// ==== hprc_field_reg.sv ====
// Purpose: One configuration field with load and reset value
// Assumes: Single clock, synchronous active-high reset
// Notes: Load has priority over hold
`timescale 1ns/10ps
`default_nettype none
module hprc_field_reg #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] value
);
  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (load) begin
      value_next = load_value;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule : hprc_field_reg
`default_nettype wire

// ==== hprc_config_regs.sv ====
// Purpose: Charge-enable and port-removable configuration registers of a four-port hub
// Assumes: Writes come from the EEPROM loader or SMBus slave on the core clock
// Notes: Read data appears one cycle after the read address; unmapped reads give zero
// Operation
// - Unused upper bits read zero, ignore writes
// - Unlock bit gates removable flag writability; charge enables stay writable
// - Unlock clear: removable flags read only, from OTP
// - Unlock set: fields loadable by EEPROM/SMBus
// - One write sets unlock and removable together
// - Removable flag 1 removable, 0 fixed
// - Flag bit n serves downstream port n+1
// - Removable writes ignored while locked unless bit 7 sets unlock
// - Locked flags read inverted OTP non-removable bits
`timescale 1ns/10ps
`default_nettype none
module hprc_config_regs
  import hprc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_wr_en,
  input wire logic [HPRC_ADDR_W-1:0] cfg_wr_addr,
  input wire logic [HPRC_DATA_W-1:0] cfg_wr_data,
  input wire logic [HPRC_ADDR_W-1:0] cfg_rd_addr,
  output logic [HPRC_DATA_W-1:0] cfg_rd_data,
  input wire logic [HPRC_PORTS-1:0] power_charge_strap_pins,
  input wire logic [HPRC_PORTS-1:0] otp_non_removable,
  output logic [HPRC_PORTS-1:0] charge_port_enable,
  output logic [HPRC_PORTS-1:0] port_removable,
  output logic custom_removable_unlock
);
  // Strap synchroniser runs through reset so it is settled at release
  logic [HPRC_PORTS-1:0] strap_meta_reg;
  logic [HPRC_PORTS-1:0] strap_sync_reg;
  logic load_pending_reg;
  logic load_pending_next;
  logic [HPRC_DATA_W-1:0] rd_data_reg;
  logic [HPRC_DATA_W-1:0] rd_data_next;
  logic wr_charge;
  logic wr_removable;
  logic charge_load;
  logic [HPRC_PORTS-1:0] charge_load_value;
  logic rmbl_load;
  logic [HPRC_PORTS-1:0] rmbl_custom;

  always_ff @(posedge clk) begin
    strap_meta_reg <= power_charge_strap_pins;
    strap_sync_reg <= strap_meta_reg;
  end

  assign wr_charge = cfg_wr_en && (cfg_wr_addr == HPRC_OFS_CHARGE);
  assign wr_removable = cfg_wr_en && (cfg_wr_addr == HPRC_OFS_REMOVABLE);

  always_comb begin
    load_pending_next = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      load_pending_reg <= 1'b1;
    end else begin
      load_pending_reg <= load_pending_next;
    end
  end

  // Strap load on the first edge after release beats a colliding write
  assign charge_load = load_pending_reg || wr_charge;
  assign charge_load_value = load_pending_reg ? strap_sync_reg
                                              : cfg_wr_data[HPRC_PORTS-1:0];

  hprc_field_reg #(
    .WIDTH(HPRC_PORTS),
    .RESET_VALUE(HPRC_CHARGE_RST)
  ) u_charge (
    .clk(clk),
    .reset(reset),
    .load(charge_load),
    .load_value(charge_load_value),
    .value(charge_port_enable)
  );

  hprc_field_reg #(
    .WIDTH(1),
    .RESET_VALUE(HPRC_UNLOCK_RST)
  ) u_unlock (
    .clk(clk),
    .reset(reset),
    .load(wr_removable),
    .load_value(cfg_wr_data[HPRC_UNLOCK_BIT]),
    .value(custom_removable_unlock)
  );

  // New unlock value counts, so one write can unlock and set flags
  assign rmbl_load = wr_removable
                     && (custom_removable_unlock || cfg_wr_data[HPRC_UNLOCK_BIT]);

  hprc_field_reg #(
    .WIDTH(HPRC_PORTS),
    .RESET_VALUE(HPRC_RMBL_RST)
  ) u_rmbl (
    .clk(clk),
    .reset(reset),
    .load(rmbl_load),
    .load_value(cfg_wr_data[HPRC_PORTS-1:0]),
    .value(rmbl_custom)
  );

  // Flags are registered; the mux looks at what the store holds after
  // this edge, so a write shows on the port on the same edge as in the store
  logic unlock_after_wr;
  logic [HPRC_PORTS-1:0] rmbl_after_wr;
  logic [HPRC_PORTS-1:0] port_removable_reg;
  logic [HPRC_PORTS-1:0] port_removable_next;

  assign unlock_after_wr = wr_removable ? cfg_wr_data[HPRC_UNLOCK_BIT]
                                        : custom_removable_unlock;
  assign rmbl_after_wr = rmbl_load ? cfg_wr_data[HPRC_PORTS-1:0] : rmbl_custom;

  // Bit n is port n+1 throughout; locked flags trail OTP by one cycle
  always_comb begin
    port_removable_next = ~otp_non_removable;
    if (unlock_after_wr) begin
      port_removable_next = rmbl_after_wr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      port_removable_reg <= ~otp_non_removable;
    end else begin
      port_removable_reg <= port_removable_next;
    end
  end

  assign port_removable = port_removable_reg;

  always_comb begin
    rd_data_next = HPRC_READ_ZERO;
    case (cfg_rd_addr)
      HPRC_OFS_CHARGE: begin
        rd_data_next = {HPRC_UPPER_ZERO, charge_port_enable};
      end
      HPRC_OFS_REMOVABLE: begin
        rd_data_next = {custom_removable_unlock, HPRC_RSVD_ZERO, port_removable};
      end
      default: begin
        rd_data_next = HPRC_READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_reg <= HPRC_READ_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign cfg_rd_data = rd_data_reg;

  AST_CHARGE_UPPER_ZERO: assert property (@(posedge clk) disable iff (reset)
    $past(cfg_rd_addr) == HPRC_OFS_CHARGE
    |-> cfg_rd_data == {HPRC_UPPER_ZERO, $past(charge_port_enable)})
    else $error("Charge register read data wrong");

  AST_RMBL_RSVD_ZERO: assert property (@(posedge clk) disable iff (reset)
    $past(cfg_rd_addr) == HPRC_OFS_REMOVABLE |-> cfg_rd_data[6:4] == HPRC_RSVD_ZERO)
    else $error("Removable register reserved bits not zero");

  AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (reset)
    cfg_rd_addr != HPRC_OFS_CHARGE && cfg_rd_addr != HPRC_OFS_REMOVABLE
    |=> cfg_rd_data == HPRC_READ_ZERO)
    else $error("Unmapped read returned nonzero data");

  AST_LOCKED_FROM_OTP: assert property (@(posedge clk) disable iff (reset)
    !custom_removable_unlock |-> port_removable == ~$past(otp_non_removable))
    else $error("Locked removable flags do not follow OTP");

  AST_UNLOCK_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_removable && cfg_wr_data[HPRC_UNLOCK_BIT]
    |=> custom_removable_unlock
      && port_removable == $past(cfg_wr_data[HPRC_PORTS-1:0]))
    else $error("Single unlocking write did not set flags");

  AST_LOCK_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_removable && !cfg_wr_data[HPRC_UNLOCK_BIT]
    |=> !custom_removable_unlock ##0 port_removable == ~$past(otp_non_removable))
    else $error("Clearing unlock did not return flags to OTP");

  AST_UNLOCK_HOLD: assert property (@(posedge clk) disable iff (reset)
    !wr_removable |=> $stable(custom_removable_unlock))
    else $error("Unlock bit changed without a write");

  AST_UNLOCKED_FLAGS: assert property (@(posedge clk) disable iff (reset)
    custom_removable_unlock && !wr_removable |=> port_removable == $past(rmbl_custom))
    else $error("Unlocked flags do not follow the store");

  AST_LOCKED_IGNORED: assert property (@(posedge clk) disable iff (reset)
    wr_removable && !custom_removable_unlock && !cfg_wr_data[HPRC_UNLOCK_BIT]
    |=> $stable(rmbl_custom))
    else $error("Locked write changed removable store");

  AST_RESET_STATE: assert property (@(posedge clk)
    reset |=> !custom_removable_unlock && charge_port_enable == HPRC_CHARGE_RST
      && cfg_rd_data == HPRC_READ_ZERO)
    else $error("Reset did not clear the registers");

  AST_STRAP_LOAD: assert property (@(posedge clk)
    $past(reset) && !reset |=> charge_port_enable == $past(strap_sync_reg))
    else $error("Charge enables not loaded from straps at release");

  AST_STRAP_WINS: assert property (@(posedge clk) disable iff (reset)
    wr_charge && load_pending_reg |=> charge_port_enable == $past(strap_sync_reg))
    else $error("Write beat the strap load at release");

  AST_CHARGE_WRITE: assert property (@(posedge clk) disable iff (reset)
    wr_charge && !load_pending_reg
    |=> charge_port_enable == $past(cfg_wr_data[HPRC_PORTS-1:0]))
    else $error("Charge enable write not taken");

  AST_CHARGE_HOLD: assert property (@(posedge clk) disable iff (reset)
    !wr_charge && !load_pending_reg |=> $stable(charge_port_enable))
    else $error("Charge enables changed without cause");

  AST_READ_MAP: assert property (@(posedge clk) disable iff (reset)
    cfg_rd_addr == HPRC_OFS_REMOVABLE ##1 $stable(port_removable)
    |-> cfg_rd_data[HPRC_PORTS-1:0] == port_removable)
    else $error("Removable read data bit order wrong");
endmodule : hprc_config_regs
`default_nettype wire

// ==== hprc_host_model.sv ====
// Purpose: Write-side model of the EEPROM loader or SMBus host
// Assumes: One-cycle write strobe on the core clock
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module hprc_host_model
  import hprc_pkg::*;
(
  input wire logic clk,
  output logic cfg_wr_en,
  output logic [HPRC_ADDR_W-1:0] cfg_wr_addr,
  output logic [HPRC_DATA_W-1:0] cfg_wr_data
);
  initial begin
    cfg_wr_en = 1'b0;
    cfg_wr_addr = 8'h00;
    cfg_wr_data = 8'h00;
  end
  // One byte per access, strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr_en <= 1'b1;
    cfg_wr_addr <= a;
    cfg_wr_data <= d;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
    // Stale values would hide a design that samples late
    cfg_wr_addr <= ~a;
    cfg_wr_data <= ~d;
    #1;
  endtask : wr
endmodule : hprc_host_model
`default_nettype wire

// ==== hprc_config_regs_tb.sv ====
// Purpose: Self-checking bench of the charge and removable registers
// Assumes: Host model issues writes, bench drives reads, straps and OTP
// Notes: Strap and OTP values are held steady across reset release
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module hprc_config_regs_tb
  import hprc_pkg::*;
;
  logic clk, reset, wr_en;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  logic [3:0] straps, otp, charge, rem;
  logic unlock;
  int failures = 0;
  int n_tests = 0;
  hprc_host_model host (.clk(clk), .cfg_wr_en(wr_en), .cfg_wr_addr(wr_addr),
    .cfg_wr_data(wr_data));
  hprc_config_regs uut (.clk(clk), .reset(reset), .cfg_wr_en(wr_en),
    .cfg_wr_addr(wr_addr), .cfg_wr_data(wr_data), .cfg_rd_addr(rd_addr),
    .cfg_rd_data(rd_data), .power_charge_strap_pins(straps),
    .otp_non_removable(otp), .charge_port_enable(charge), .port_removable(rem),
    .custom_removable_unlock(unlock));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  // Read data answers the address of the previous edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    #1;
    `CHK(rd_data, e)
  endtask : rd
  initial begin
    #20000;
    failures++;
    close_out();
  end
  initial begin
    reset = 1'b1;
    rd_addr = 8'h00;
    straps = 4'ha;
    otp = 4'h3;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(charge, 4'ha)
    `CHK(rem, 4'hc)
    `CHK(unlock, 1'b0)
    rd(8'h06, 8'h0a);
    rd(8'h07, 8'h0c);
    rd(8'h08, 8'h00);
    host.wr(8'h07, 8'h05);
    `CHK(rem, 4'hc)
    @(posedge clk);
    otp <= 4'h5;
    // Flags are registered, so new OTP shows one edge later
    @(posedge clk);
    #1;
    `CHK(rem, 4'ha)
    host.wr(8'h07, 8'h85);
    `CHK(unlock, 1'b1)
    `CHK(rem, 4'h5)
    rd(8'h07, 8'h85);
    host.wr(8'h07, 8'hfa);
    rd(8'h07, 8'h8a);
    host.wr(8'h06, 8'hf5);
    `CHK(charge, 4'h5)
    rd(8'h06, 8'h05);
    host.wr(8'h07, 8'h03);
    `CHK(unlock, 1'b0)
    `CHK(rem, 4'ha)
    host.wr(8'h07, 8'h8c);
    `CHK(rem, 4'hc)
    // Mid-run reset with new straps; a charge write on the release edge loses
    @(posedge clk);
    straps <= 4'h6;
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    fork
      host.wr(8'h06, 8'h0f);
      begin
        @(posedge clk);
        reset <= 1'b0;
      end
    join
    `CHK(charge, 4'h6)
    `CHK(unlock, 1'b0)
    `CHK(rem, 4'ha)
    host.wr(8'h08, 8'hff);
    `CHK(charge, 4'h6)
    `CHK(unlock, 1'b0)
    rd(8'h06, 8'h06);
    close_out();
  end
endmodule : hprc_config_regs_tb
`default_nettype wire
